// file: logic/gpf_pin_functions.sv
// Design: role selection and dedicated functions of nine general lines
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: Each line is GPIO, chip select or dedicated function, one role only.
// R2: Lines 0 to 7 as GPIO are each input or output.
// R3: Line 8 is input only and never drives.
// R4: Read returns all GPIO levels; write changes only output lines.
// R5: Chip select lines take idle or active level from SPI engine.
// R6: Suspend line 2 goes low in Suspend, high on Resume.
// R7: Configured line 5 is high from reset until configured.
// R8: Configured line 5 goes low once configuration completes.
// R9: After configuration, line 5 high in Suspend, low on resume.
// R10: Device enters Suspend when suspend signalling is seen.
// R11: Traffic-free interval over 3 ms is taken as suspend request.
// R12: Resume signalling, bus reset or device reset leave Suspend.
// R13: Low power line shows host refused power, device unconfigured.
// R14: Line 4 low after reset, high configured, low in Suspend.
// R15: External event input on line 6 is counted.
// R16: Counter counts falling, rising edges, low or high pulses.
// R17: Line 8 carries bus release request, monitored by device.
// R18: Line 7 acknowledges that SPI bus has been released.
// R19: Release at once if idle, else after transfer ends or cancels.
// R20: Line 3 indicates SPI traffic.
// R21: Traffic line low during transfer, high when idle.
// R22: GPIO writes never change chip select or dedicated lines.
module gpf_pin_functions
    import gpf_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [15:0]          role_sel,
    input  wire logic [7:0]           gpio_dir_out,
    input  wire logic                 gpio_wr,
    input  wire logic [7:0]           gpio_wr_data,
    output logic [8:0]                gpio_rd_data,
    input  wire gpf_spi_s             spi_stat,
    input  wire logic                 release_enable,
    output logic                      bus_released,
    input  wire logic                 usb_traffic,
    input  wire logic                 usb_resume_sig,
    input  wire logic                 usb_bus_reset,
    input  wire logic                 usb_configured,
    input  wire logic                 power_refused,
    output logic                      suspended,
    input  wire logic [1:0]           evt_mode,
    input  wire logic                 evt_clear,
    output logic [EVT_CNT_W-1:0]      evt_count,
    input  wire logic [8:0]           line_in,
    output logic [7:0]                line_out,
    output logic [7:0]                line_oe
);

    // ----------------------------------------------------------------
    // Role decode
    // ----------------------------------------------------------------

    // Two role bits per line to an enum
    function automatic gpf_role_e role_of(input logic [15:0] sel,
                                          input int unsigned idx);
        logic [1:0] code;
        code = sel[2*idx +: 2];
        case (code)
            2'd1:    role_of = GPF_ROLE_CS;
            2'd2:    role_of = GPF_ROLE_DEDICATED;
            default: role_of = GPF_ROLE_GPIO;
        endcase
    endfunction

    wire logic [7:0] is_gpio;
    wire logic [7:0] is_cs;
    wire logic [7:0] is_ded;

    // R1: one role per line
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IO_LINES; gi++) begin : g_role
            assign is_gpio[gi] = (role_of(role_sel, gi) == GPF_ROLE_GPIO);
            assign is_cs[gi]   = (role_of(role_sel, gi) == GPF_ROLE_CS);
            assign is_ded[gi]  = (role_of(role_sel, gi)
                                  == GPF_ROLE_DEDICATED);
        end
    endgenerate

    // ----------------------------------------------------------------
    // USB suspend and configuration tracking
    // ----------------------------------------------------------------
    logic [IDLE_CNT_W-1:0] idle_cnt;
    logic                  configured;
    wire logic             idle_expired;
    wire logic             wake;

    // R11: longer than 3 ms without traffic
    assign idle_expired = (32'(idle_cnt) >= IDLE_SUSPEND_CYCLES);
    // R12: resume signalling or bus reset
    assign wake = usb_resume_sig | usb_bus_reset;

    // Idle counter restarts on any traffic
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            idle_cnt <= '0;
        end else if (usb_traffic || wake) begin
            idle_cnt <= '0;
        end else if (!idle_expired) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // R10: suspend on detected signalling; R12: reset clears it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            suspended <= 1'b0;
        end else if (wake || usb_traffic) begin
            suspended <= 1'b0;
        end else if (idle_expired) begin
            suspended <= 1'b1;
        end
    end

    // R8: configuration latched; bus reset drops it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            configured <= 1'b0;
        end else if (usb_bus_reset) begin
            configured <= 1'b0;
        end else if (usb_configured && !power_refused) begin
            configured <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // SPI bus release
    // ----------------------------------------------------------------
    wire logic  release_req;

    // R17: request is line 8 driven low while release_enable is set
    assign release_req = release_enable & ~line_in[8];

    // R19: release at once when idle, else at transfer end or cancel
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_released <= 1'b0;
        end else if (!release_req) begin
            bus_released <= 1'b0;
        end else if (!spi_stat.busy || spi_stat.done || spi_stat.cancel) begin
            bus_released <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // External event counter
    // ----------------------------------------------------------------
    logic      evt_prev;
    wire logic evt_rise;
    wire logic evt_fall;
    wire logic evt_hit;

    assign evt_rise = line_in[LINE_EVENT] & ~evt_prev;
    assign evt_fall = ~line_in[LINE_EVENT] & evt_prev;

    // R16: a pulse is counted at its closing edge
    assign evt_hit = (evt_mode == 2'(GPF_EVT_FALL))       ? evt_fall :
                     (evt_mode == 2'(GPF_EVT_RISE))       ? evt_rise :
                     (evt_mode == 2'(GPF_EVT_LOW_PULSE))  ? evt_rise :
                                                            evt_fall;

    // R15: count events while line 6 is dedicated
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            evt_prev  <= 1'b1;
            evt_count <= '0;
        end else begin
            evt_prev <= line_in[LINE_EVENT];
            if (evt_hit && is_ded[LINE_EVENT]) begin
                evt_count <= evt_count + 1'b1;
            end else if (evt_clear) begin
                evt_count <= '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // GPIO output latch
    // ----------------------------------------------------------------
    logic [7:0]      gpio_out;
    wire logic [7:0] gpio_wmask;

    // R4: R22: only GPIO outputs take a write
    assign gpio_wmask = is_gpio & gpio_dir_out;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gpio_out <= GPIO_OUT_RESET;
        end else if (gpio_wr) begin
            gpio_out <= (gpio_out & ~gpio_wmask)
                      | (gpio_wr_data & gpio_wmask);
        end
    end

    // ----------------------------------------------------------------
    // Dedicated function levels
    // ----------------------------------------------------------------
    wire logic [7:0] ded_level;
    wire logic [7:0] ded_oe;
    wire logic [7:0] cs_level;

    // R6: suspend line active low
    assign ded_level[LINE_SUSPEND] = ~suspended;
    // R20: R21: traffic line low while busy
    assign ded_level[LINE_LED]     = ~spi_stat.busy;
    // R13: R14: low power line
    assign ded_level[LINE_LOW_POWER] = configured & ~suspended;
    // R7: R9: configured line
    assign ded_level[LINE_CONFIG]  = ~(configured & ~suspended);
    assign ded_level[LINE_EVENT]   = 1'b1;
    // R18: acknowledge of release
    assign ded_level[LINE_REL_ACK] = bus_released;
    assign ded_level[1:0]          = 2'b11;
    assign ded_oe = 8'hBC;

    // R5: chip select level by transfer state
    assign cs_level = spi_stat.busy ? spi_stat.cs_active : spi_stat.cs_idle;

    // ----------------------------------------------------------------
    // Pin drive registers
    // ----------------------------------------------------------------
    gpf_drive_s next_drive;
    gpf_drive_s drive;

    // R1: R2: select per line
    always_comb begin
        next_drive.out = (is_gpio & gpio_out) | (is_cs & cs_level)
                       | (is_ded & ded_level);
        next_drive.oe  = (is_gpio & gpio_dir_out) | is_cs
                       | (is_ded & ded_oe);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drive <= '0;
        end else begin
            drive <= next_drive;
        end
    end

    // R3: line 8 has no output at all
    assign line_out = drive.out;
    assign line_oe  = drive.oe;

    // R4: read all levels
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gpio_rd_data <= '0;
        end else begin
            gpio_rd_data <= line_in;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_gpio_write_mask: assert property ( // R22
        @(posedge sys_clk) disable iff (rst)
        gpio_wr |=> ((gpio_out & ~$past(gpio_wmask))
                     == ($past(gpio_out) & ~$past(gpio_wmask))))
        else $error("GPIO write touched a non-output line");

    chk_led_level: assert property ( // R21
        @(posedge sys_clk) disable iff (rst)
        is_ded[LINE_LED] |=> (line_out[LINE_LED] == !$past(spi_stat.busy)))
        else $error("Traffic line level wrong");

    chk_release_idle: assert property ( // R19
        @(posedge sys_clk) disable iff (rst)
        (release_req && !spi_stat.busy) |=> bus_released)
        else $error("Bus not released while idle");

    chk_release_busy: assert property ( // R19
        @(posedge sys_clk) disable iff (rst)
        (release_req && spi_stat.busy && !spi_stat.done
         && !spi_stat.cancel) |=> !bus_released || $past(bus_released))
        else $error("Bus released during transfer");

    chk_suspend_entry: assert property ( // R11
        @(posedge sys_clk) disable iff (rst)
        (idle_expired && !usb_traffic && !wake) |=> suspended)
        else $error("Suspend not entered after idle");

    chk_wake_exit: assert property ( // R12
        @(posedge sys_clk) disable iff (rst)
        wake |=> !suspended)
        else $error("Suspend not left on wake");

    chk_cfg_line: assert property ( // R9
        @(posedge sys_clk) disable iff (rst)
        (is_ded[LINE_CONFIG] && suspended) |=> line_out[LINE_CONFIG])
        else $error("Configured line low in suspend");

    chk_evt_count: assert property ( // R16
        @(posedge sys_clk) disable iff (rst)
        (evt_hit && is_ded[LINE_EVENT])
            |=> evt_count == $past(evt_count) + 1'b1)
        else $error("Event not counted");

    chk_cs_drive: assert property ( // R5
        @(posedge sys_clk) disable iff (rst)
        is_cs[0] |=> (line_oe[0] && line_out[0]
                      == $past(spi_stat.busy ? spi_stat.cs_active[0]
                                             : spi_stat.cs_idle[0])))
        else $error("Chip select level wrong");

    chk_role_unique: assert property ( // R1
        @(posedge sys_clk) disable iff (rst)
        ((is_gpio ^ is_cs ^ is_ded) == 8'hFF)
            && ((is_gpio & is_cs & is_ded) == 8'h00))
        else $error("Line holds more than one role");

    chk_gpio_input_oe: assert property ( // R2
        @(posedge sys_clk) disable iff (rst)
        (|(is_gpio & ~gpio_dir_out))
            |=> ((line_oe & $past(is_gpio & ~gpio_dir_out)) == 8'h00))
        else $error("GPIO input line driven");

    chk_suspend_line: assert property ( // R6
        @(posedge sys_clk) disable iff (rst)
        is_ded[LINE_SUSPEND]
            |=> (line_out[LINE_SUSPEND] == !$past(suspended)))
        else $error("Suspend line level wrong");

    chk_low_power_line: assert property ( // R14
        @(posedge sys_clk) disable iff (rst)
        is_ded[LINE_LOW_POWER]
            |=> (line_out[LINE_LOW_POWER] == $past(configured && !suspended)))
        else $error("Low power line level wrong");

    chk_cfg_level: assert property ( // R8
        @(posedge sys_clk) disable iff (rst)
        is_ded[LINE_CONFIG]
            |=> (line_out[LINE_CONFIG] == !$past(configured && !suspended)))
        else $error("Configured line level wrong");

    chk_power_refused: assert property ( // R13
        @(posedge sys_clk) disable iff (rst)
        (power_refused && !configured) |=> !configured)
        else $error("Configured although power refused");

endmodule : gpf_pin_functions
`default_nettype wire

// file: inc/gpf_pkg.sv
// Package: constants and types for the general-purpose line function block
package gpf_pkg;

    // ----------------------------------------------------------------
    // Line counts and line positions
    // ----------------------------------------------------------------
    localparam int unsigned NUM_IO_LINES   = 8;
    localparam int unsigned LINE_SUSPEND   = 2;
    localparam int unsigned LINE_LED       = 3;
    localparam int unsigned LINE_LOW_POWER = 4;
    localparam int unsigned LINE_CONFIG    = 5;
    localparam int unsigned LINE_EVENT     = 6;
    localparam int unsigned LINE_REL_ACK   = 7;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ     = 200_000_000;
    localparam int unsigned IDLE_SUSPEND_US = 3_000;
    // Traffic-free interval; must be longer than this count
    localparam int unsigned IDLE_SUSPEND_CYCLES =
        (IDLE_SUSPEND_US * (CLK_FREQ_HZ / 1_000_000));
    localparam int unsigned IDLE_CNT_W = 20;

    // ----------------------------------------------------------------
    // Reset values and widths
    // ----------------------------------------------------------------
    localparam int unsigned EVT_CNT_W = 16;
    localparam logic [7:0]  GPIO_OUT_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        GPF_ROLE_GPIO,
        GPF_ROLE_CS,
        GPF_ROLE_DEDICATED
    } gpf_role_e;

    typedef enum logic [1:0] {
        GPF_EVT_FALL,
        GPF_EVT_RISE,
        GPF_EVT_LOW_PULSE,
        GPF_EVT_HIGH_PULSE
    } gpf_evt_mode_e;

    // Per-line output drive bundle
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } gpf_drive_s;

    // SPI engine status seen by the block
    typedef struct packed {
        logic       busy;
        logic       done;
        logic       cancel;
        logic [7:0] cs_idle;
        logic [7:0] cs_active;
    } gpf_spi_s;

endpackage : gpf_pkg

// file: test/gpf_board_model.sv
// Board model: pin levels seen by the block and the other SPI host
`timescale 1ns/1ps
`default_nettype none
module gpf_board_model
    import gpf_pkg::*;
(
    input  wire logic [7:0] line_out,
    input  wire logic [7:0] line_oe,
    input  wire logic [8:0] ext_level,
    output logic      [8:0] line_in
);
    // -------------------------------------------------------
    // Pin resolution
    // -------------------------------------------------------
    // Driven lines read back own level, others the board level
    assign line_in[7:0] = (line_out & line_oe) | (ext_level[7:0] & ~line_oe);
    // release request
    // Other host pulls line 8 low to ask for the bus
    assign line_in[8] = ext_level[8];
endmodule // gpf_board_model
`default_nettype wire

// file: test/tb_gpf_pin_functions.sv
// Testbench: directed checks of line roles and dedicated functions
`timescale 1ns/1ps
`default_nettype none
module tb_gpf_pin_functions
    import gpf_pkg::*;
;
    logic                 sys_clk = 1'b0;
    logic                 rst;
    logic [15:0]          role_sel;
    logic [7:0]           gpio_dir_out;
    logic                 gpio_wr;
    logic [7:0]           gpio_wr_data;
    logic [8:0]           gpio_rd_data;
    gpf_spi_s             spi_stat;
    logic                 release_enable;
    logic                 bus_released;
    logic                 usb_traffic;
    logic                 usb_resume_sig;
    logic                 usb_bus_reset;
    logic                 usb_configured;
    logic                 power_refused;
    logic                 suspended;
    logic [1:0]           evt_mode;
    logic                 evt_clear;
    logic [EVT_CNT_W-1:0] evt_count;
    logic [8:0]           line_in;
    logic [8:0]           ext_level;
    logic [7:0]           line_out;
    logic [7:0]           line_oe;
    int                   n_errors = 0;
    int                   check_count = 0;

    // Clock of 5 ns period
    always #2.5 sys_clk = ~sys_clk;

    gpf_pin_functions i_dut (
        .sys_clk(sys_clk), .rst(rst), .role_sel(role_sel),
        .gpio_dir_out(gpio_dir_out), .gpio_wr(gpio_wr),
        .gpio_wr_data(gpio_wr_data), .gpio_rd_data(gpio_rd_data),
        .spi_stat(spi_stat), .release_enable(release_enable),
        .bus_released(bus_released), .usb_traffic(usb_traffic),
        .usb_resume_sig(usb_resume_sig), .usb_bus_reset(usb_bus_reset),
        .usb_configured(usb_configured), .power_refused(power_refused),
        .suspended(suspended), .evt_mode(evt_mode), .evt_clear(evt_clear),
        .evt_count(evt_count), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe)
    );

    gpf_board_model i_board (
        .line_out(line_out), .line_oe(line_oe),
        .ext_level(ext_level), .line_in(line_in)
    );

    // -------------------------------------------------------
    // Helper tasks
    // -------------------------------------------------------
    // Let n edges pass, then sample settled outputs
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic gpio_write(input logic [7:0] data);
        @(posedge sys_clk);
        gpio_wr      <= 1'b1;
        gpio_wr_data <= data;
        @(posedge sys_clk);
        gpio_wr      <= 1'b0;
        wait_n(4);
    endtask

    // Toggle the event input k times, three cycles apart
    task automatic toggle_evt(input int k);
        repeat (k) begin
            repeat (3) @(posedge sys_clk);
            ext_level[6] <= ~ext_level[6];
        end
        wait_n(4);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        #100_000;
        n_errors++;
        $display("FAIL %0t watchdog expired", $time);
        summarize();
    end

    // -------------------------------------------------------
    // Test sequence
    // -------------------------------------------------------
    initial begin
        rst = 1'b1;
        role_sel = 16'h00FF; // Code 3 on lines 0 to 3 acts as GPIO
        gpio_dir_out = 8'h0F;
        gpio_wr = 1'b0;
        gpio_wr_data = 8'h00;
        spi_stat = '0;
        release_enable = 1'b0;
        usb_traffic = 1'b1;
        usb_resume_sig = 1'b0;
        usb_bus_reset = 1'b0;
        usb_configured = 1'b0;
        power_refused = 1'b0;
        evt_mode = 2'b00;
        evt_clear = 1'b0;
        ext_level = 9'h1_70;
        wait_n(2);
        check(line_oe, 16'h0000, "reset drive"); // all lines input
        check(bus_released, 16'h0000, "reset release"); // no ack
        check(evt_count, 16'h0000, "reset counter"); // cleared
        @(posedge sys_clk);
        rst <= 1'b0;
        $display("test reset done");

        gpio_write(8'hA5); // write
        check(line_oe, 16'h000F, "gpio dir"); // per line
        check(line_out[3:0], 16'h0005, "gpio out"); // outputs
        check(gpio_rd_data, 16'h0175, "gpio read"); // all levels
        @(posedge sys_clk);
        gpio_dir_out <= 8'hF0;
        wait_n(4);
        check(line_out[7:4], 16'h0000, "input kept"); // inputs kept
        $display("test gpio done");

        @(posedge sys_clk);
        role_sel <= 16'hAAA9;
        gpio_dir_out <= 8'hFF;
        spi_stat.cs_idle <= 8'h01;
        wait_n(4);
        check(line_oe, 16'h00BD, "role oe"); // one role
        check(line_out & line_oe, 16'h002D, "idle");
        gpio_write(8'h00); // write to other roles
        check(line_out & line_oe, 16'h002D, "write"); // not GPIO
        @(posedge sys_clk);
        spi_stat.busy <= 1'b1;
        wait_n(4);
        check(line_out & line_oe, 16'h0024, "busy"); // active
        @(posedge sys_clk);
        spi_stat.busy <= 1'b0;
        power_refused <= 1'b1;
        usb_configured <= 1'b1;
        @(posedge sys_clk);
        usb_configured <= 1'b0;
        wait_n(4);
        check(line_out & line_oe, 16'h002D, "refused"); // stays
        @(posedge sys_clk);
        power_refused <= 1'b0;
        usb_configured <= 1'b1;
        @(posedge sys_clk);
        usb_configured <= 1'b0;
        wait_n(4);
        check(line_out & line_oe, 16'h001D, "config"); // done
        check(suspended, 16'h0000, "awake"); // traffic
        @(posedge sys_clk);
        usb_bus_reset <= 1'b1;
        @(posedge sys_clk);
        usb_bus_reset <= 1'b0;
        wait_n(4);
        check(line_out & line_oe, 16'h002D, "bus reset"); // reset
        // Short traffic-free stretch with a resume pulse
        @(posedge sys_clk);
        usb_traffic <= 1'b0;
        usb_resume_sig <= 1'b1;
        @(posedge sys_clk);
        usb_resume_sig <= 1'b0;
        wait_n(50);
        check(suspended, 16'h0000, "short idle"); // under 3 ms
        @(posedge sys_clk);
        usb_traffic <= 1'b1;
        $display("test roles done");

        // Held request released by a done pulse, then by a cancel
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            release_enable <= 1'b1;
            spi_stat.busy <= 1'b1;
            ext_level[8] <= 1'b0;
            wait_n(4);
            check(bus_released, 16'h0000, "held"); // transfer on
            @(posedge sys_clk);
            spi_stat.done <= (k == 0);
            spi_stat.cancel <= (k == 1);
            @(posedge sys_clk);
            spi_stat.done <= 1'b0;
            spi_stat.cancel <= 1'b0;
            #1;
            check(bus_released, 16'h0001, "released"); // on end
            wait_n(1);
            check(line_out[7] & line_oe[7], 16'h0001, "ack"); // line 7
            @(posedge sys_clk);
            ext_level[8] <= 1'b1;
            spi_stat.busy <= 1'b0;
            wait_n(2);
            check(bus_released, 16'h0000, "dropped"); // request gone
        end
        @(posedge sys_clk);
        ext_level[8] <= 1'b0;
        wait_n(1);
        check(bus_released, 16'h0001, "idle release"); // at once
        $display("test release done");

        // Three low pulses then a final fall, in every mode
        @(posedge sys_clk);
        ext_level[6] <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            evt_mode <= m[1:0];
            evt_clear <= 1'b1;
            @(posedge sys_clk);
            evt_clear <= 1'b0;
            toggle_evt(7); // edges
            check(evt_count, 16'd3 + 16'(m == 0 || m == 3), "events");
            toggle_evt(1); // back to high
        end
        $display("test events done");
        summarize();
    end
endmodule // tb_gpf_pin_functions
`default_nettype wire
